//--- hw/mech_pkg.sv
// Purpose: constants, types and decoding for the eoc command handler
// Assumes: the monitor handshake delivers whole two-byte messages
// Notes: class nibble sits in byte0[7:4]; eoc address in byte0[3:1], d/m in byte0[0]
// Contract
// - classify two-byte messages by first nibble
// - direct register replies always go first
// - eoc messages touch internal registers only
// - one command suffices; device repeats code
// - byte0 class, address, d/m; byte1 code
// - commands come in, confirmations go out
// - eoc reply beats overhead and local replies
// - code 50 requests downstream loop first
// - code 51 loops first bearer channel
// - code 52 loops second bearer channel
// - code 53 inverts crc, stops far-end counting
// - code 54 stops near-end counting, holds indications
// - undefined code answered with unable-to-comply
// - code ff releases all, state ff
// - defined addressed command is echoed back
// - all access travels as monitor messages
// - local-function replies have lowest priority
package mech_pkg;

	// ----------------------------------------------------------------
	// widths and message fields
	// ----------------------------------------------------------------
	localparam int MECH_BYTE_W = 8;
	localparam logic [3:0] MECH_CLASS_EOC = 4'h0;
	localparam logic [3:0] MECH_CLASS_OHB = 4'h2;
	localparam logic [3:0] MECH_CLASS_LF = 4'h8;
	localparam logic [3:0] MECH_CLASS_DRC = 4'hC;
	localparam logic [2:0] MECH_ADDR_NT = 3'h0;
	localparam logic [2:0] MECH_ADDR_BCAST = 3'h7;

	// ----------------------------------------------------------------
	// eoc codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MECH_CODE_HOLD = 8'h00;
	localparam logic [7:0] MECH_CODE_FULL_LOOP = 8'h50;
	localparam logic [7:0] MECH_CODE_FIRST_LOOP = 8'h51;
	localparam logic [7:0] MECH_CODE_SECOND_LOOP = 8'h52;
	localparam logic [7:0] MECH_CODE_REQ_CRC = 8'h53;
	localparam logic [7:0] MECH_CODE_NOTIFY_CRC = 8'h54;
	localparam logic [7:0] MECH_CODE_UNABLE = 8'hAA;
	localparam logic [7:0] MECH_CODE_RELEASE = 8'hFF;
	localparam logic [7:0] MECH_EOC_STATE_RESET = 8'hFF;
	// second byte of the local full_loop_close command
	localparam logic [7:0] MECH_LF_FULL_LOOP_CODE = 8'hF4;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MECH_CLS_NONE = 3'b000,
		MECH_CLS_EOC = 3'b001,
		MECH_CLS_OHB = 3'b010,
		MECH_CLS_LF = 3'b011,
		MECH_CLS_DRC = 3'b100
	} mech_class_t;

	typedef enum logic [1:0] {
		MECH_LOOP_OPEN = 2'b00,
		MECH_LOOP_REQUESTED = 2'b01,
		MECH_LOOP_CLOSED = 2'b10
	} mech_loop_t;

	// class from first nibble; anything else maps to none
	function automatic mech_class_t mech_class_of(input logic [7:0] byte0);
		logic [3:0] nib;
		nib = byte0[7:4];
		if (nib == MECH_CLASS_EOC) mech_class_of = MECH_CLS_EOC;
		else if (nib == MECH_CLASS_OHB) mech_class_of = MECH_CLS_OHB;
		else if (nib == MECH_CLASS_LF) mech_class_of = MECH_CLS_LF;
		else if (nib == MECH_CLASS_DRC) mech_class_of = MECH_CLS_DRC;
		else mech_class_of = MECH_CLS_NONE;
	endfunction : mech_class_of

	// true for the seven codes the processor understands
	function automatic logic mech_code_defined(input logic [7:0] code);
		mech_code_defined = (code == MECH_CODE_HOLD) || (code == MECH_CODE_FULL_LOOP)
			|| (code == MECH_CODE_FIRST_LOOP) || (code == MECH_CODE_SECOND_LOOP)
			|| (code == MECH_CODE_REQ_CRC) || (code == MECH_CODE_NOTIFY_CRC)
			|| (code == MECH_CODE_RELEASE);
	endfunction : mech_code_defined

endpackage : mech_pkg

//--- hw/mech_msg_if.sv
// Purpose: two-byte monitor message with valid/ready handshake
// Assumes: sender holds valid and bytes until ready
// Notes: ready may be combinational
interface mech_msg_if;
	logic valid;
	logic ready;
	logic [7:0] byte0;
	logic [7:0] byte1;
	modport sender (output valid, output byte0, output byte1, input ready);
	modport receiver (input valid, input byte0, input byte1, output ready);
endinterface : mech_msg_if

//--- hw/mech_classifier.sv
// Purpose: take a monitor message and split out its fields
// Assumes: message source is logic on the same clock
// Notes: accept is a combinational one-cycle strobe
module mech_classifier (
	mech_msg_if.receiver msg,
	input wire logic busy_in,
	output logic accept_out,
	output mech_pkg::mech_class_t cls_out,
	output logic [2:0] addr_out,
	output logic dm_out,
	output logic [7:0] code_out
);
	import mech_pkg::*;

	// stall the whole stream while an eoc answer still waits for the arbiter
	assign msg.ready = !busy_in;
	assign accept_out = msg.valid && !busy_in;

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	assign cls_out = mech_class_of(msg.byte0);
	assign addr_out = msg.byte0[3:1];
	assign dm_out = msg.byte0[0];
	assign code_out = msg.byte1;
endmodule : mech_classifier

//--- hw/mech_reply_arb.sv
// Purpose: fixed-priority choice of replies for one output slot
// Assumes: each source holds its request until its ready pulse
// Notes: priority direct register, then eoc, then overhead, then local function
module mech_reply_arb (
	input wire logic clk_in,
	input wire logic rst_b_in,
	mech_msg_if.receiver drc,
	mech_msg_if.receiver eoc,
	mech_msg_if.receiver ohb,
	mech_msg_if.receiver lf,
	output logic reply_valid_out,
	output logic [7:0] reply_byte0_out,
	output logic [7:0] reply_byte1_out,
	input wire logic reply_ready_in
);
	import mech_pkg::*;

	logic slot_free;
	logic take_drc;
	logic take_eoc;
	logic take_ohb;
	logic take_lf;
	logic take_any;
	logic [7:0] win_byte0;
	logic [7:0] win_byte1;

	// the slot frees as it is read, so replies go back to back
	assign slot_free = !reply_valid_out || reply_ready_in;
	assign take_drc = slot_free && drc.valid;
	assign take_eoc = slot_free && eoc.valid && !drc.valid;
	assign take_ohb = slot_free && ohb.valid && !drc.valid && !eoc.valid;
	assign take_lf = slot_free && lf.valid && !drc.valid && !eoc.valid && !ohb.valid;
	assign take_any = take_drc || take_eoc || take_ohb || take_lf;
	assign drc.ready = take_drc;
	assign eoc.ready = take_eoc;
	assign ohb.ready = take_ohb;
	assign lf.ready = take_lf;

	// winner data select
	assign win_byte0 = take_drc ? drc.byte0 : take_eoc ? eoc.byte0 : take_ohb ? ohb.byte0 : lf.byte0;
	assign win_byte1 = take_drc ? drc.byte1 : take_eoc ? eoc.byte1 : take_ohb ? ohb.byte1 : lf.byte1;

	// output slot
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reply_valid_out <= 1'b0;
			reply_byte0_out <= 8'h00;
			reply_byte1_out <= 8'h00;
		end else if (slot_free) begin
			reply_valid_out <= take_any;
			reply_byte0_out <= take_any ? win_byte0 : reply_byte0_out;
			reply_byte1_out <= take_any ? win_byte1 : reply_byte1_out;
		end
	end
endmodule : mech_reply_arb

//--- hw/mech_top.sv
// Purpose: monitor message interpreter with eoc command execution and reply priority
// Assumes: all inputs come from logic on CLOCK_IN; monitor handshake is outside
// Notes: eoc effects are latched levels until release, except the one-cycle downstream loop requests
module mech_top (
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	input wire logic MSG_VALID_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] MSG_BYTE0_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] MSG_BYTE1_IN,
	output logic MSG_READY_OUT,
	input wire logic DRC_REPLY_VALID_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] DRC_REPLY_BYTE0_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] DRC_REPLY_BYTE1_IN,
	output logic DRC_REPLY_TAKEN_OUT,
	input wire logic OHB_REPLY_VALID_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] OHB_REPLY_BYTE0_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] OHB_REPLY_BYTE1_IN,
	output logic OHB_REPLY_TAKEN_OUT,
	input wire logic LF_REPLY_VALID_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] LF_REPLY_BYTE0_IN,
	input wire logic [mech_pkg::MECH_BYTE_W-1:0] LF_REPLY_BYTE1_IN,
	output logic LF_REPLY_TAKEN_OUT,
	output logic REPLY_VALID_OUT,
	output logic [mech_pkg::MECH_BYTE_W-1:0] REPLY_BYTE0_OUT,
	output logic [mech_pkg::MECH_BYTE_W-1:0] REPLY_BYTE1_OUT,
	input wire logic REPLY_READY_IN,
	output logic DRC_CMD_OUT,
	output logic OHB_CMD_OUT,
	output logic LF_CMD_OUT,
	output logic [mech_pkg::MECH_BYTE_W-1:0] CMD_BYTE0_OUT,
	output logic [mech_pkg::MECH_BYTE_W-1:0] CMD_BYTE1_OUT,
	input wire logic DOWNSTREAM_TRANSPARENT_IN,
	output logic DOWNSTREAM_LOOP_REQ_A_OUT,
	output logic DOWNSTREAM_LOOP_REQ_B_OUT,
	output logic FULL_LOOP_CLOSE_OUT,
	output logic FIRST_BEARER_LOOP_OUT,
	output logic SECOND_BEARER_LOOP_OUT,
	output logic CRC_INVERT_UP_OUT,
	output logic FAR_END_COUNT_STOP_OUT,
	output logic NEAR_END_COUNT_STOP_OUT,
	output logic ERROR_IND_HOLD_OUT,
	output logic [mech_pkg::MECH_BYTE_W-1:0] EOC_LINE_CODE_OUT
);
	import mech_pkg::*;

	// ----------------------------------------------------------------
	// carriers between the submodules
	// ----------------------------------------------------------------
	mech_msg_if in_msg ();
	mech_msg_if drc_rep ();
	mech_msg_if eoc_rep ();
	mech_msg_if ohb_rep ();
	mech_msg_if lf_rep ();

	logic accept;
	mech_class_t cls;
	logic [2:0] addr;
	logic dm;
	logic [7:0] code;
	logic eoc_pend;
	logic [7:0] eoc_rep_byte0;
	logic [7:0] eoc_rep_byte1;
	logic [7:0] eoc_state;
	mech_loop_t loop_state;
	mech_loop_t next_loop_state;
	logic first_loop;
	logic second_loop;
	logic crc_invert;
	logic far_stop;
	logic near_stop;
	logic err_hold;
	logic req_a;
	logic req_b;
	logic fwd_drc;
	logic fwd_ohb;
	logic fwd_lf;
	logic [7:0] fwd_byte0;
	logic [7:0] fwd_byte1;

	// incoming message from the monitor channel
	assign in_msg.valid = MSG_VALID_IN;
	assign in_msg.byte0 = MSG_BYTE0_IN;
	assign in_msg.byte1 = MSG_BYTE1_IN;
	assign MSG_READY_OUT = in_msg.ready;

	// replies waiting in other units of the device
	assign drc_rep.valid = DRC_REPLY_VALID_IN;
	assign drc_rep.byte0 = DRC_REPLY_BYTE0_IN;
	assign drc_rep.byte1 = DRC_REPLY_BYTE1_IN;
	assign DRC_REPLY_TAKEN_OUT = drc_rep.ready;
	assign ohb_rep.valid = OHB_REPLY_VALID_IN;
	assign ohb_rep.byte0 = OHB_REPLY_BYTE0_IN;
	assign ohb_rep.byte1 = OHB_REPLY_BYTE1_IN;
	assign OHB_REPLY_TAKEN_OUT = ohb_rep.ready;
	assign lf_rep.valid = LF_REPLY_VALID_IN;
	assign lf_rep.byte0 = LF_REPLY_BYTE0_IN;
	assign lf_rep.byte1 = LF_REPLY_BYTE1_IN;
	assign LF_REPLY_TAKEN_OUT = lf_rep.ready;
	assign eoc_rep.valid = eoc_pend;
	assign eoc_rep.byte0 = eoc_rep_byte0;
	assign eoc_rep.byte1 = eoc_rep_byte1;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	mech_classifier u_classifier (
		.msg(in_msg),
		.busy_in(eoc_pend),
		.accept_out(accept),
		.cls_out(cls),
		.addr_out(addr),
		.dm_out(dm),
		.code_out(code)
	);

	mech_reply_arb u_reply_arb (
		.clk_in(CLOCK_IN),
		.rst_b_in(RST_B_IN),
		.drc(drc_rep),
		.eoc(eoc_rep),
		.ohb(ohb_rep),
		.lf(lf_rep),
		.reply_valid_out(REPLY_VALID_OUT),
		.reply_byte0_out(REPLY_BYTE0_OUT),
		.reply_byte1_out(REPLY_BYTE1_OUT),
		.reply_ready_in(REPLY_READY_IN)
	);

	// ----------------------------------------------------------------
	// eoc decode
	// ----------------------------------------------------------------
	logic eoc_take;
	logic addressed;
	logic exec;
	logic code_ok;
	logic do_full;
	logic do_first;
	logic do_second;
	logic do_rcc;
	logic do_ncc;
	logic do_release;
	logic lf_full_loop;
	logic [7:0] answer;

	assign eoc_take = accept && (cls == MECH_CLS_EOC);
	// only termination or broadcast with d/m set acts
	assign addressed = ((addr == MECH_ADDR_NT) || (addr == MECH_ADDR_BCAST)) && dm;
	assign code_ok = mech_code_defined(code);
	assign exec = eoc_take && addressed && code_ok;
	assign do_full = exec && (code == MECH_CODE_FULL_LOOP);
	assign do_first = exec && (code == MECH_CODE_FIRST_LOOP);
	assign do_second = exec && (code == MECH_CODE_SECOND_LOOP);
	assign do_rcc = exec && (code == MECH_CODE_REQ_CRC);
	assign do_ncc = exec && (code == MECH_CODE_NOTIFY_CRC);
	assign do_release = exec && (code == MECH_CODE_RELEASE);
	assign lf_full_loop = accept && (cls == MECH_CLS_LF) && (code == MECH_LF_FULL_LOOP_CODE);

	// answer code: hold when not for us, refusal when unknown, else echo
	assign answer = !addressed ? MECH_CODE_HOLD
		: !code_ok ? MECH_CODE_UNABLE
		: code;

	// pending eoc answer; input stalls meanwhile
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			eoc_pend <= 1'b0;
			eoc_rep_byte0 <= 8'h00;
			eoc_rep_byte1 <= 8'h00;
		end else if (eoc_take) begin
			eoc_pend <= 1'b1;
			eoc_rep_byte0 <= {MECH_CLASS_EOC, addr, dm};
			eoc_rep_byte1 <= answer;
		end else if (eoc_rep.ready) begin
			eoc_pend <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// eoc processor state and line code
	// ----------------------------------------------------------------
	// hold and refused codes leave the state alone; the code stays on the line
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			eoc_state <= MECH_EOC_STATE_RESET;
		end else if (exec && (code != MECH_CODE_HOLD)) begin
			eoc_state <= code;
		end
	end

	// the framer repeats it every line frame
	assign EOC_LINE_CODE_OUT = eoc_state;

	// ----------------------------------------------------------------
	// latched test and loop functions
	// ----------------------------------------------------------------
	// each of codes 51 to 54 adds to the set; release clears everything at once
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			first_loop <= 1'b0;
			second_loop <= 1'b0;
			crc_invert <= 1'b0;
			far_stop <= 1'b0;
			near_stop <= 1'b0;
			err_hold <= 1'b0;
		end else if (do_release) begin
			first_loop <= 1'b0;
			second_loop <= 1'b0;
			crc_invert <= 1'b0;
			far_stop <= 1'b0;
			near_stop <= 1'b0;
			err_hold <= 1'b0;
		end else begin
			first_loop <= first_loop || do_first;
			second_loop <= second_loop || do_second;
			crc_invert <= crc_invert || do_rcc;
			far_stop <= far_stop || do_rcc;
			near_stop <= near_stop || do_ncc;
			err_hold <= err_hold || do_rcc || do_ncc;
		end
	end

	assign FIRST_BEARER_LOOP_OUT = first_loop;
	assign SECOND_BEARER_LOOP_OUT = second_loop;
	assign CRC_INVERT_UP_OUT = crc_invert;
	assign FAR_END_COUNT_STOP_OUT = far_stop;
	assign NEAR_END_COUNT_STOP_OUT = near_stop;
	assign ERROR_IND_HOLD_OUT = err_hold;

	// ----------------------------------------------------------------
	// full loop sequencing
	// ----------------------------------------------------------------
	// the loop is never closed on code 50 itself: downstream gets the first chance
	always_comb begin
		next_loop_state = loop_state;
		case (loop_state)
			MECH_LOOP_OPEN: begin
				if (do_full) next_loop_state = MECH_LOOP_REQUESTED;
			end
			MECH_LOOP_REQUESTED: begin
				if (do_release) next_loop_state = MECH_LOOP_OPEN;
				else if (lf_full_loop) next_loop_state = MECH_LOOP_CLOSED;
			end
			MECH_LOOP_CLOSED: begin
				if (do_release) next_loop_state = MECH_LOOP_OPEN;
			end
			default: begin
				next_loop_state = MECH_LOOP_OPEN;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			loop_state <= MECH_LOOP_OPEN;
		end else begin
			loop_state <= next_loop_state;
		end
	end

	assign FULL_LOOP_CLOSE_OUT = (loop_state == MECH_LOOP_CLOSED);

	// one-cycle downstream request, form per downstream state
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			req_a <= 1'b0;
			req_b <= 1'b0;
		end else begin
			req_a <= do_full && DOWNSTREAM_TRANSPARENT_IN;
			req_b <= do_full && !DOWNSTREAM_TRANSPARENT_IN;
		end
	end

	assign DOWNSTREAM_LOOP_REQ_A_OUT = req_a;
	assign DOWNSTREAM_LOOP_REQ_B_OUT = req_b;

	// ----------------------------------------------------------------
	// forwarding of the other classes
	// ----------------------------------------------------------------
	// unknown class nibbles raise no strobe and get no answer
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			fwd_drc <= 1'b0;
			fwd_ohb <= 1'b0;
			fwd_lf <= 1'b0;
			fwd_byte0 <= 8'h00;
			fwd_byte1 <= 8'h00;
		end else begin
			fwd_drc <= accept && (cls == MECH_CLS_DRC);
			fwd_ohb <= accept && (cls == MECH_CLS_OHB);
			fwd_lf <= accept && (cls == MECH_CLS_LF);
			fwd_byte0 <= accept ? in_msg.byte0 : fwd_byte0;
			fwd_byte1 <= accept ? in_msg.byte1 : fwd_byte1;
		end
	end

	assign DRC_CMD_OUT = fwd_drc;
	assign OHB_CMD_OUT = fwd_ohb;
	assign LF_CMD_OUT = fwd_lf;
	assign CMD_BYTE0_OUT = fwd_byte0;
	assign CMD_BYTE1_OUT = fwd_byte1;
endmodule : mech_top

//--- bench/mech_monitor.sv
// Purpose: port checks for the eoc command handler
// Assumes: one clock, async active-low reset
// Notes: eoc answers carry class nibble 0000
module mech_monitor (
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	input wire logic MSG_VALID_IN,
	input wire logic [7:0] MSG_BYTE0_IN,
	input wire logic [7:0] MSG_BYTE1_IN,
	input wire logic MSG_READY_OUT,
	input wire logic DRC_REPLY_VALID_IN,
	input wire logic DRC_REPLY_TAKEN_OUT,
	input wire logic OHB_REPLY_TAKEN_OUT,
	input wire logic LF_REPLY_TAKEN_OUT,
	input wire logic REPLY_VALID_OUT,
	input wire logic [7:0] REPLY_BYTE0_OUT,
	input wire logic [7:0] REPLY_BYTE1_OUT,
	input wire logic REPLY_READY_IN,
	input wire logic DRC_CMD_OUT,
	input wire logic OHB_CMD_OUT,
	input wire logic LF_CMD_OUT,
	input wire logic DOWNSTREAM_TRANSPARENT_IN,
	input wire logic DOWNSTREAM_LOOP_REQ_A_OUT,
	input wire logic DOWNSTREAM_LOOP_REQ_B_OUT,
	input wire logic FULL_LOOP_CLOSE_OUT,
	input wire logic FIRST_BEARER_LOOP_OUT,
	input wire logic CRC_INVERT_UP_OUT,
	input wire logic FAR_END_COUNT_STOP_OUT,
	input wire logic [7:0] EOC_LINE_CODE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import mech_pkg::*;
	default clocking mon_clk @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	// take decoding
	wire logic [3:0] nib = MSG_BYTE0_IN[7:4];
	wire logic take = MSG_VALID_IN && MSG_READY_OUT;
	wire logic eoc_take = take && (nib == MECH_CLASS_EOC);
	wire logic nt_or_all = (MSG_BYTE0_IN[3:1] == MECH_ADDR_NT) || (MSG_BYTE0_IN[3:1] == 3'h7);
	wire logic addressed = MSG_BYTE0_IN[0] && nt_or_all;
	wire logic lf_close = take && (nib == MECH_CLASS_LF)
		&& (MSG_BYTE1_IN == MECH_LF_FULL_LOOP_CODE);
	wire logic known = (nib == MECH_CLASS_EOC) || (nib == 4'h2) || (nib == 4'h8) || (nib == 4'hC);
	wire logic slot_free = !REPLY_VALID_OUT || REPLY_READY_IN;

	// addressed command, then its answer
	sequence s_cmd(logic [7:0] code);
		eoc_take && addressed && (MSG_BYTE1_IN == code);
	endsequence
	sequence s_eoc_answer;
		##[2:40] (REPLY_VALID_OUT && (REPLY_BYTE0_OUT[7:4] == MECH_CLASS_EOC));
	endsequence

	a_eoc_stalls_input: assert property (eoc_take |=> !MSG_READY_OUT)
		else $error("input taken while pending");
	a_eoc_answer_due: assert property (eoc_take |-> s_eoc_answer)
		else $error("eoc answer missing");
	a_direct_first: assert property (DRC_REPLY_VALID_IN && slot_free |-> DRC_REPLY_TAKEN_OUT)
		else $error("direct reply not first");
	a_eoc_beats_low: assert property (!MSG_READY_OUT |-> !OHB_REPLY_TAKEN_OUT && !LF_REPLY_TAKEN_OUT)
		else $error("low reply beat eoc");
	a_reply_holds: assert property (REPLY_VALID_OUT && !REPLY_READY_IN |=> REPLY_VALID_OUT
		&& $stable(REPLY_BYTE0_OUT) && $stable(REPLY_BYTE1_OUT))
		else $error("reply slot changed");
	a_first_loop_set: assert property (s_cmd(MECH_CODE_FIRST_LOOP) |=> FIRST_BEARER_LOOP_OUT
		&& (EOC_LINE_CODE_OUT == MECH_CODE_FIRST_LOOP))
		else $error("first loop missing");
	a_crc_request: assert property (s_cmd(MECH_CODE_REQ_CRC) |=> CRC_INVERT_UP_OUT
		&& FAR_END_COUNT_STOP_OUT)
		else $error("crc request missing");
	a_release_all: assert property (s_cmd(MECH_CODE_RELEASE) |=> !FIRST_BEARER_LOOP_OUT
		&& !CRC_INVERT_UP_OUT && !FULL_LOOP_CLOSE_OUT && (EOC_LINE_CODE_OUT == 8'hFF))
		else $error("release incomplete");
	a_hold_no_change: assert property (eoc_take && (!addressed || MSG_BYTE1_IN == 8'h00) |=>
		$stable(EOC_LINE_CODE_OUT) && $stable(FIRST_BEARER_LOOP_OUT))
		else $error("hold changed state");
	a_loop_request: assert property (s_cmd(MECH_CODE_FULL_LOOP) |=>
		(DOWNSTREAM_LOOP_REQ_A_OUT == $past(DOWNSTREAM_TRANSPARENT_IN))
		&& (DOWNSTREAM_LOOP_REQ_B_OUT != $past(DOWNSTREAM_TRANSPARENT_IN)))
		else $error("wrong loop request");
	a_loop_cause: assert property ($rose(FULL_LOOP_CLOSE_OUT) |-> $past(lf_close))
		else $error("loop closed early");
	a_unknown_silent: assert property (take && !known |=> !DRC_CMD_OUT && !OHB_CMD_OUT
		&& !LF_CMD_OUT && MSG_READY_OUT)
		else $error("unknown class acted");
endmodule : mech_monitor

bind mech_top mech_monitor mech_monitor_inst (.*);

//--- bench/mech_reply_sink.sv
// Purpose: controller model taking replies
// Assumes: stall from the bench
// Notes: registered ready, so a stall bites one edge late
module mech_reply_sink (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic stall_in,
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// not ready in reset, nothing taken early
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= !stall_in;
		end
	end
endmodule : mech_reply_sink

//--- bench/tb.sv
// Purpose: bench for the eoc command handler
// Assumes: sink model drives reply ready
// Notes: status = {cmd, req a/b, full, b1, b2, crc, far, near, hold}
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mech_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic msg_v = 1'b0;
	logic [7:0] msg_b0 = 8'h00;
	logic [7:0] msg_b1 = 8'h00;
	logic [2:0] src_v = 3'h0;
	logic [15:0] drc_rep = 16'hC123;
	logic [15:0] ohb_rep = 16'h2A0B;
	logic [15:0] lf_rep = 16'h8005;
	logic transp = 1'b0;
	logic stall = 1'b0;
	int fails = 0;
	int checks_done = 0;
	logic [15:0] replies [$];
	wire logic msg_ready, rep_v, rep_ready, req_a, req_b, full, first, second, crc, far, near, hold;
	wire logic [2:0] taken, cmd;
	wire logic [7:0] rep_b0, rep_b1, cmd_b0, cmd_b1, line_code;
	wire logic [11:0] status = {cmd, req_a, req_b, full, first, second, crc, far, near, hold};
	// eoc rows: byte0, byte1, answer, status, line code
	logic [40:0] rows [0:8] = '{
		{8'h01, 8'h51, 8'h51, 9'h020, 8'h51},
		{8'h0F, 8'h52, 8'h52, 9'h030, 8'h52},
		{8'h01, 8'h53, 8'h53, 9'h03D, 8'h53},
		{8'h01, 8'h54, 8'h54, 9'h03F, 8'h54},
		{8'h01, 8'h37, 8'hAA, 9'h03F, 8'h54},
		{8'h01, 8'h00, 8'h00, 9'h03F, 8'h54},
		{8'h07, 8'h51, 8'h00, 9'h03F, 8'h54},
		{8'h00, 8'h51, 8'h00, 9'h03F, 8'h54},
		{8'h01, 8'hFF, 8'hFF, 9'h000, 8'hFF}};
	logic [15:0] cls [0:3] = '{16'h2A33, 16'h8005, 16'hC311, 16'h5A77};
	logic [11:0] cls_exp [0:3] = '{12'h400, 12'h200, 12'h800, 12'h000};

	mech_top mech_top_inst (.CLOCK_IN(clk), .RST_B_IN(rst_b), .MSG_VALID_IN(msg_v),
		.MSG_BYTE0_IN(msg_b0), .MSG_BYTE1_IN(msg_b1), .MSG_READY_OUT(msg_ready),
		.DRC_REPLY_VALID_IN(src_v[2]), .DRC_REPLY_BYTE0_IN(drc_rep[15:8]),
		.DRC_REPLY_BYTE1_IN(drc_rep[7:0]), .DRC_REPLY_TAKEN_OUT(taken[2]),
		.OHB_REPLY_VALID_IN(src_v[1]), .OHB_REPLY_BYTE0_IN(ohb_rep[15:8]),
		.OHB_REPLY_BYTE1_IN(ohb_rep[7:0]), .OHB_REPLY_TAKEN_OUT(taken[1]),
		.LF_REPLY_VALID_IN(src_v[0]), .LF_REPLY_BYTE0_IN(lf_rep[15:8]),
		.LF_REPLY_BYTE1_IN(lf_rep[7:0]), .LF_REPLY_TAKEN_OUT(taken[0]),
		.REPLY_VALID_OUT(rep_v), .REPLY_BYTE0_OUT(rep_b0), .REPLY_BYTE1_OUT(rep_b1),
		.REPLY_READY_IN(rep_ready), .DRC_CMD_OUT(cmd[2]), .OHB_CMD_OUT(cmd[1]),
		.LF_CMD_OUT(cmd[0]), .CMD_BYTE0_OUT(cmd_b0), .CMD_BYTE1_OUT(cmd_b1),
		.DOWNSTREAM_TRANSPARENT_IN(transp), .DOWNSTREAM_LOOP_REQ_A_OUT(req_a),
		.DOWNSTREAM_LOOP_REQ_B_OUT(req_b), .FULL_LOOP_CLOSE_OUT(full),
		.FIRST_BEARER_LOOP_OUT(first), .SECOND_BEARER_LOOP_OUT(second),
		.CRC_INVERT_UP_OUT(crc), .FAR_END_COUNT_STOP_OUT(far), .NEAR_END_COUNT_STOP_OUT(near),
		.ERROR_IND_HOLD_OUT(hold), .EOC_LINE_CODE_OUT(line_code));
	mech_reply_sink mech_reply_sink_inst (.clk_in(clk), .rst_b_in(rst_b), .stall_in(stall),
		.ready_out(rep_ready));

	// sources drop valid when taken; replies logged
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (taken[i] === 1'b1) src_v[i] <= 1'b0;
		end
		if (rep_v === 1'b1 && rep_ready === 1'b1) replies.push_back({rep_b0, rep_b1});
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
		end
	endtask : compare
	// held until ready is seen high
	task automatic send(input logic [7:0] b0, input logic [7:0] b1);
		int n = 0;
		@(posedge clk);
		msg_v <= 1'b1;
		msg_b0 <= b0;
		msg_b1 <= b1;
		@(negedge clk);
		while (msg_ready !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		compare({15'h0, msg_ready}, 16'h0001, "input ready");
		@(posedge clk);
		msg_v <= 1'b0;
	endtask : send
	task automatic expect_reply(input logic [15:0] exp, input string what);
		int n = 0;
		while (replies.size() == 0 && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (replies.size() == 0) replies.push_back(16'hXXXX);
		compare(replies.pop_front(), exp, what);
	endtask : expect_reply
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_check();
		@(negedge clk);
		compare({4'h0, status}, 16'h0000, "reset status");
		compare({8'h00, line_code}, 16'h00FF, "reset code");
		compare({15'h0, msg_ready}, 16'h0001, "reset ready");
	endtask : t_reset_check
	task automatic t_eoc_table();
		for (int i = 0; i < 9; i++) begin
			send(rows[i][40:33], rows[i][32:25]);
			@(negedge clk);
			compare({4'h0, status}, {7'h00, rows[i][16:8]}, "eoc effects");
			compare({8'h00, line_code}, {8'h00, rows[i][7:0]}, "line code");
			expect_reply({rows[i][40:33], rows[i][24:17]}, "eoc answer");
		end
	endtask : t_eoc_table
	task automatic t_full_loop();
		for (int t = 0; t < 2; t++) begin
			@(posedge clk);
			transp <= t[0];
			send(8'h01, MECH_CODE_FULL_LOOP);
			@(negedge clk);
			compare({4'h0, status}, (t == 1) ? 16'h0100 : 16'h0080, "loop request");
			@(negedge clk);
			compare({4'h0, status}, 16'h0000, "loop open");
			expect_reply(16'h0150, "loop echo");
			send(8'h80, MECH_LF_FULL_LOOP_CODE);
			@(negedge clk);
			compare({4'h0, status}, 16'h0240, "loop closed");
			send(8'h01, 8'hFF);
			@(negedge clk);
			compare({4'h0, status}, 16'h0000, "loop released");
			expect_reply(16'h01FF, "release echo");
		end
	endtask : t_full_loop
	task automatic t_classes();
		for (int i = 0; i < 4; i++) begin
			send(cls[i][15:8], cls[i][7:0]);
			@(negedge clk);
			compare({4'h0, status}, {4'h0, cls_exp[i]}, "class strobe");
			compare({cmd_b0, cmd_b1}, cls[i], "fwd bytes");
		end
		repeat (10) @(negedge clk);
		compare({15'h0, replies.size() == 0}, 16'h0001, "class replies");
	endtask : t_classes
	// all sources wait behind a stalled sink
	task automatic t_priority();
		@(posedge clk);
		stall <= 1'b1;
		src_v <= 3'h7;
		send(8'h01, 8'h00);
		repeat (8) @(posedge clk);
		stall <= 1'b0;
		expect_reply(drc_rep, "direct reply");
		expect_reply(16'h0100, "eoc answer");
		expect_reply(ohb_rep, "overhead reply");
		expect_reply(lf_rep, "local reply");
	endtask : t_priority
	task automatic t_mid_reset();
		send(8'h01, MECH_CODE_REQ_CRC);
		expect_reply(16'h0153, "crc echo");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset_check();
		@(posedge clk);
		rst_b <= 1'b1;
	endtask : t_mid_reset

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset_check();
		t_eoc_table();
		t_full_loop();
		t_classes();
		t_priority();
		t_mid_reset();
		summarize();
	end
	// watchdog: run needs under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		summarize();
	end
endmodule : tb
